// ==== tw_serial_unit.sv ====
// Purpose: Universal serial unit in two-wire slave role with helpers
// Assumes: Software runs the protocol through the register port
// Notes:   Bus lines sampled through two flops; start detect is sampled
`timescale 1ns/1ps
module tw_serial_unit (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic [3:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            irq_start,
	output logic            irq_ovf,
	output logic            wake,
	tw_bus_if.dev           bus
);

	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic       scl_p;
		logic       sda_p;
		logic [7:0] ctrl;
		logic [7:0] port;
		logic [7:0] shreg;
		logic [3:0] cnt;
		logic [7:0] timer;
		logic       start_f;
		logic       ovf_f;
		logic       hold;
		logic       armed;
		logic [7:0] rdata;
	} state_t;

	state_t q, d;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic scl_r;
		logic scl_f;
		logic sda_f;
		logic two;
		logic ext;
		logic tick;
		logic start_ev;
		logic any_edge;
		logic [4:0] inc;
		d        = q;
		scl_r    = q.scl_s[1] & ~q.scl_p;
		scl_f    = ~q.scl_s[1] & q.scl_p;
		sda_f    = ~q.sda_s[1] & q.sda_p;
		two      = q.ctrl[tw_pkg::CTRL_MODE_LO+1 -: 2] ==
			tw_pkg::MODE_TWO;
		ext      = q.ctrl[tw_pkg::CTRL_CSEL_LO+1];
		d.scl_s  = {q.scl_s[0], bus.scl};
		d.sda_s  = {q.sda_s[0], bus.sda};
		d.scl_p  = q.scl_s[1];
		d.sda_p  = q.sda_s[1];
		// Start: SDA falls while SCL high, two-wire only
		start_ev = two & sda_f & q.scl_s[1];
		any_edge = ~two & (q.ctrl[tw_pkg::CTRL_CSEL_LO+1 -: 2] >=
			tw_pkg::CSEL_EXT_P) & ~q.ctrl[tw_pkg::CTRL_STROBE] &
			(scl_r | scl_f);
		// Counter ticks: both pin edges, or software strobe
		tick = (ext & ~q.ctrl[tw_pkg::CTRL_STROBE] & (scl_r | scl_f)) |
			(ext & q.ctrl[tw_pkg::CTRL_STROBE] & wr &
			addr == tw_pkg::REG_CTRL & wdata[tw_pkg::CTRL_TOGGLE]) |
			(~ext & wr & addr == tw_pkg::REG_CTRL &
			wdata[tw_pkg::CTRL_TOGGLE]);
		// Shift in on rising SCL, external clock source only
		if (ext & scl_r) begin
			d.shreg = {q.shreg[6:0], q.sda_s[1]};
		end
		inc = {1'b0, q.cnt} + 5'h01;
		if (tick) begin
			d.cnt = inc[3:0];
			if (inc[4]) begin
				d.ovf_f = 1'b1;
				d.timer = q.timer + 8'h01;
			end
		end
		if (start_ev) d.armed = 1'b1;
		if (q.armed & scl_f) begin
			d.hold  = 1'b1;
			d.armed = 1'b0;
		end
		// Register writes; flag clears lose to sets
		if (wr) begin
			if (addr == tw_pkg::REG_CTRL) begin
				d.ctrl = wdata & ~(8'h01 << tw_pkg::CTRL_TOGGLE);
			end else if (addr == tw_pkg::REG_STATUS) begin
				if (wdata[tw_pkg::STAT_START]) d.start_f = 1'b0;
				if (wdata[tw_pkg::STAT_OVF]) d.ovf_f = 1'b0;
				d.cnt = wdata[3:0];
			end else if (addr == tw_pkg::REG_DATA) begin
				d.shreg = wdata;
			end else if (addr == tw_pkg::REG_PORT) begin
				d.port = wdata;
			end else if (addr == tw_pkg::REG_TIMER) begin
				d.timer = wdata;
			end
		end
		if (start_ev | any_edge) d.start_f = 1'b1;
		if (tick & inc[4]) d.ovf_f = 1'b1;
		// Hold ends once start flag is clear
		if (q.hold & ~d.start_f) d.hold = 1'b0;
		d.rdata = 8'h00;
		if (rd) begin
			if (addr == tw_pkg::REG_CTRL) d.rdata = q.ctrl;
			else if (addr == tw_pkg::REG_STATUS) begin
				d.rdata = {q.start_f, q.ovf_f, q.hold, 1'b0, q.cnt};
			end else if (addr == tw_pkg::REG_DATA) d.rdata = q.shreg;
			else if (addr == tw_pkg::REG_PORT) begin
				d.rdata = q.port;
			end else if (addr == tw_pkg::REG_TIMER) d.rdata = q.timer;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q       <= '0;
			q.scl_s <= 2'h3;
			q.sda_s <= 2'h3;
			q.scl_p <= 1'b1;
			q.sda_p <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------
	// Pins and status outputs
	// ------------------------------------------------------------
	assign bus.sda_o_dev    = q.shreg[7] & q.port[tw_pkg::PORT_SDA_LATCH];
	assign bus.sda_oe_n_dev = ~q.port[tw_pkg::PORT_SDA_DIR] | bus.sda_o_dev;
	// SCL pulled by hold, overflow in two-wire, or port latch
	assign bus.scl_o_dev    = 1'b0;
	assign bus.scl_oe_n_dev = ~(q.hold | (q.ovf_f &
		q.ctrl[1:0] == tw_pkg::MODE_TWO) | (q.port[tw_pkg::PORT_SCL_DIR]
		& ~q.port[tw_pkg::PORT_SCL_LATCH]));
	assign rdata     = q.rdata;
	assign irq_start = q.start_f & q.ctrl[tw_pkg::CTRL_SIE];
	assign irq_ovf   = q.ovf_f & q.ctrl[tw_pkg::CTRL_OIE];
	assign wake      = irq_start;

endmodule : tw_serial_unit

// ==== tw_pkg.sv ====
// Purpose: Shared constants for the two-wire serial unit and its bus master
// Assumes: 20 MHz system clock, register port with one-cycle read latency
// Notes:   Register offsets are fixed here only; status and mode field positions are also hard-coded in the unit
//
// Overview of operation
// - Master starts by pulling SDA low, SCL high
// - SDA low when shift bit 7 or latch zero
// - SDA driven only when direction bit set
// - Start detection sets start flag
// - After start, hold SCL low at falling edge
// - Software clears start flag, resets counter, releases
// - Shift SDA in on rising SCL edges
// - Counter overflow after eight bits forces SCL low
// - Unaddressed slave releases SCL, waits next start
// - Acknowledge low, counter preloaded to fourteen
// - Direction bit one means slave drives SDA
// - Slave may stretch SCL after acknowledge
// - Bytes flow one direction until stop/restart
// - Full slave withholds acknowledge on last byte
// - Master read ends via final acknowledge bit
// - Start detection only in two-wire mode
// - Other modes: any clock edge sets start flag; here only SCL edges, with external clock source and strobe select off
// - Start detector needs no running system clock; here it is sampled on clk_sys
// - External clock counts both pin edges
// - Preload fifteen, one edge overflows counter
// - Counter chains with companion timer, twelve bits
// - Software strobes can overflow the counter
package tw_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [3:0] REG_CTRL   = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h1;
	localparam logic [3:0] REG_DATA   = 4'h2;
	localparam logic [3:0] REG_PORT   = 4'h3;
	localparam logic [3:0] REG_TIMER  = 4'h4;

	// ------------------------------------------------------------
	// Control fields
	// ------------------------------------------------------------
	localparam int CTRL_MODE_LO   = 0;  // 2 bits: 0 off,1 three,2 two-wire
	localparam int CTRL_CSEL_LO   = 2;  // clock_source_select, 2 bits
	localparam int CTRL_STROBE    = 4;  // clock_strobe_select
	localparam int CTRL_TOGGLE    = 5;  // Software clock strobe, reads 0
	localparam int CTRL_SIE       = 6;
	localparam int CTRL_OIE       = 7;

	// ------------------------------------------------------------
	// Status fields
	// ------------------------------------------------------------
	localparam int STAT_CNT_LO    = 0;  // 4-bit counter
	localparam int STAT_SCL_HOLD  = 5;
	localparam int STAT_OVF       = 6;
	localparam int STAT_START     = 7;

	// Port register fields
	localparam int PORT_SDA_LATCH = 0;
	localparam int PORT_SDA_DIR   = 1;
	localparam int PORT_SCL_LATCH = 2;
	localparam int PORT_SCL_DIR   = 3;

	localparam logic [1:0] MODE_OFF   = 2'h0;
	localparam logic [1:0] MODE_THREE = 2'h1;
	localparam logic [1:0] MODE_TWO   = 2'h2;
	localparam logic [1:0] CSEL_EXT_P = 2'h2;
	localparam logic [1:0] CSEL_EXT_N = 2'h3;

	localparam logic [3:0] CNT_ACK    = 4'hE;
	localparam logic [3:0] CNT_MAX    = 4'hF;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_NS         = 50;
	localparam int SCL_HALF_NS    = 5000;
	localparam int SCL_HALF_CYC   = SCL_HALF_NS / CLK_NS;
	localparam logic [7:0] RESET_CTRL = 8'h00;
	localparam logic [7:0] RESET_PORT = 8'h00;

	// ------------------------------------------------------------
	// Master command codes
	// ------------------------------------------------------------
	localparam logic [1:0] CMD_START  = 2'h0;
	localparam logic [1:0] CMD_WRITE  = 2'h1;
	localparam logic [1:0] CMD_READ   = 2'h2;
	localparam logic [1:0] CMD_STOP   = 2'h3;

endpackage : tw_pkg

// ==== tw_bus_if.sv ====
// Purpose: Two-wire bus between the serial unit and the far-side master
// Assumes: Open-drain lines, pull-up when nobody pulls low
// Notes:   oe is active low: low means the party pulls the line low
`timescale 1ns/1ps
interface tw_bus_if;
	logic scl_o_dev;
	logic scl_oe_n_dev;
	logic sda_o_dev;
	logic sda_oe_n_dev;
	logic scl_o_mst;
	logic scl_oe_n_mst;
	logic sda_o_mst;
	logic sda_oe_n_mst;
	logic scl;
	logic sda;

	// Wired-AND resolution with pull-up
	assign scl = (scl_oe_n_dev | scl_o_dev) & (scl_oe_n_mst | scl_o_mst);
	assign sda = (sda_oe_n_dev | sda_o_dev) & (sda_oe_n_mst | sda_o_mst);

	modport dev (input scl, input sda, output scl_o_dev, output scl_oe_n_dev,
		output sda_o_dev, output sda_oe_n_dev);
	modport mst (input scl, input sda, output scl_o_mst, output scl_oe_n_mst,
		output sda_o_mst, output sda_oe_n_mst);
endinterface : tw_bus_if

// ==== tw_bus_master.sv ====
// Purpose: Far-side two-wire master driven by simple byte commands
// Assumes: Slave may stretch SCL; master waits while SCL is held low
// Notes:   SCL made by a divider of clk_sys
`timescale 1ns/1ps
module tw_bus_master (
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_last,
	output logic            cmd_ready,
	output logic      [7:0] rsp_data,
	output logic            rsp_ack,
	output logic            rsp_valid,
	tw_bus_if.mst           bus
);

	typedef enum logic [2:0] {
		S_IDLE = 3'b000, S_LOW = 3'b001, S_HIGH = 3'b010,
		S_STA  = 3'b011, S_STO = 3'b100
	} st_t;

	typedef struct packed {
		st_t        st;
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [7:0] div;
		logic [3:0] bit_n;
		logic [8:0] sh;
		logic       rdm;
		logic       scl_o;
		logic       sda_o;
		logic [7:0] rdat;
		logic       ack;
		logic       rv;
	} mst_t;

	mst_t q, d;

	// ------------------------------------------------------------
	// Master sequencer
	// ------------------------------------------------------------
	always_comb begin
		logic done;
		d       = q;
		d.scl_s = {q.scl_s[0], bus.scl};
		d.sda_s = {q.sda_s[0], bus.sda};
		d.rv    = 1'b0;
		done    = q.div == 8'(tw_pkg::SCL_HALF_CYC - 1);
		d.div   = done ? 8'h00 : q.div + 8'h01;
		case (q.st)
			S_IDLE: begin
				d.div = 8'h00;
				if (cmd_valid) begin
					d.bit_n = 4'h0;
					d.rdm   = cmd == tw_pkg::CMD_READ;
					// Read: release SDA, ack from cmd_last
					d.sh    = (cmd == tw_pkg::CMD_READ) ? {8'hFF, cmd_last}
						: {cmd_data, 1'b1};
					if (cmd == tw_pkg::CMD_START) begin
						d.st = S_STA;
						d.sda_o = 1'b1;
					end else if (cmd == tw_pkg::CMD_STOP) begin
						d.st = S_STO;
						d.sda_o = 1'b0;
					end else begin
						d.st = S_LOW;
						// First bit set up a full low phase ahead of SCL
						d.sda_o = (cmd == tw_pkg::CMD_READ) | cmd_data[7];
					end
				end
			end
			// Start: SDA falls a half period before SCL does
			S_STA: if (done) begin
				if (~q.scl_o) begin
					d.scl_o = 1'b1;
				end else if (q.scl_s[1] & q.sda_o) begin
					d.sda_o = 1'b0;
				end else if (~q.sda_o) begin
					d.st    = S_IDLE;
					d.rv    = 1'b1;
					d.scl_o = 1'b0;
				end
			end
			S_LOW: if (done) begin
				d.scl_o = 1'b1;
				d.st    = S_HIGH;
			end
			// Wait for a stretched SCL, then a full high phase
			S_HIGH: if (~q.scl_s[1]) begin
				d.div = 8'h00;
			end else if (done) begin
				d.sh    = {q.sh[7:0], q.sda_s[1]};
				d.scl_o = 1'b0;
				d.bit_n = q.bit_n + 4'h1;
				if (q.bit_n == 4'h8) begin
					d.rdat = q.sh[7:0];
					d.ack  = ~q.sda_s[1];
					d.rv   = 1'b1;
					d.st   = S_IDLE;
					d.sda_o = 1'b1;
				end else begin
					d.st    = S_LOW;
					d.sda_o = q.sh[7]; // Next bit while SCL is low
				end
			end
			S_STO: if (done) begin
				if (~q.scl_o) d.scl_o = 1'b1;
				else if (q.scl_s[1]) begin
					d.sda_o = 1'b1;
					d.st    = S_IDLE;
					d.rv    = 1'b1;
				end
			end
			default: d.st = S_IDLE;
		endcase
		if (q.rdm & q.st == S_HIGH & done & q.scl_s[1] & q.bit_n == 4'h8) begin
			d.rdat = q.sh[7:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			q       <= '0;
			q.st    <= S_IDLE;
			q.scl_s <= 2'h3;
			q.sda_s <= 2'h3;
			q.scl_o <= 1'b1;
			q.sda_o <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	assign cmd_ready        = q.st == S_IDLE;
	assign rsp_data         = q.rdat;
	assign rsp_ack          = q.ack;
	assign rsp_valid        = q.rv;
	assign bus.scl_o_mst    = 1'b0;
	assign bus.scl_oe_n_mst = q.scl_o;
	assign bus.sda_o_mst    = 1'b0;
	assign bus.sda_oe_n_mst = q.sda_o;

endmodule : tw_bus_master

// ==== tw_line_asserts.sv ====
// Purpose: Line checks between the serial unit and the bus master
// Assumes: Both ends are design modules joined by one tw_bus_if
// Notes:   Helper counters track SCL rises and SCL phase lengths
`timescale 1ns/1ps
module tw_line_asserts (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic scl_oe_n_dev,
	input wire logic sda_oe_n_dev,
	input wire logic scl_oe_n_mst
);
	localparam int HALF = tw_pkg::SCL_HALF_CYC - 4;
	logic [3:0] rise_q;
	logic [7:0] high_q;
	logic [7:0] low_q;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	// SCL rises since the unit let go, and length of each SCL phase
	always_ff @(posedge clk_sys) begin
		if (rst || !scl_oe_n_dev) rise_q <= 4'h0;
		else if ($rose(scl)) rise_q <= rise_q + 4'h1;
		high_q <= !scl ? 8'h00 : high_q + {7'h00, high_q != 8'hFF};
		low_q  <= scl ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
	end

	property p_hold_low; $fell(scl_oe_n_dev) |-> !scl; endproperty
	a_hold_low: assert property (p_hold_low)
		else $error("unit pulled SCL in a high phase");
	property p_sda_in_low; $changed(sda_oe_n_dev) |-> !scl; endproperty
	a_sda_in_low: assert property (p_sda_in_low)
		else $error("unit moved SDA while SCL high");
	property p_hold_count;
		$fell(scl_oe_n_dev) |-> rise_q inside {4'h0, 4'h1, 4'h8};
	endproperty
	a_hold_count: assert property (p_hold_count)
		else $error("unit held SCL after a wrong bit count");
	property p_byte_hold;
		$fell(scl) && rise_q == 4'h8 |-> ##[1:6] !scl_oe_n_dev;
	endproperty
	a_byte_hold: assert property (p_byte_hold)
		else $error("no SCL hold after eight bits");
	property p_start_setup; $fell(sda) && scl |=> scl [*8]; endproperty
	a_start_setup: assert property (p_start_setup)
		else $error("SCL fell too soon after start");
	property p_mst_high; $fell(scl_oe_n_mst) |-> high_q >= HALF; endproperty
	a_mst_high: assert property (p_mst_high)
		else $error("master cut an SCL high phase short");
	property p_mst_low; $rose(scl_oe_n_mst) |-> low_q >= HALF; endproperty
	a_mst_low: assert property (p_mst_low)
		else $error("master cut an SCL low phase short");
	property p_mst_wait; scl_oe_n_mst && !scl |=> scl_oe_n_mst; endproperty
	a_mst_wait: assert property (p_mst_wait)
		else $error("master pulled SCL while stretched");

	// Main scenarios
	c_start: cover property ($fell(sda) && scl);
	c_byte: cover property ($fell(scl_oe_n_dev) && rise_q == 4'h8);
	c_ack: cover property ($rose(scl) && !sda_oe_n_dev);
endmodule : tw_line_asserts

// ==== two_wire_serial_unit_start_detect_bench.sv ====
// Purpose: Self-checking bench for the serial unit and its bus master
// Assumes: The unit acts as addressed slave, its software runs here
// Notes:   Register reads sample rdata one cycle after the strobe
`timescale 1ns/1ps
module two_wire_serial_unit_start_detect_bench;
	localparam logic [3:0] CT = tw_pkg::REG_CTRL;
	localparam logic [3:0] ST = tw_pkg::REG_STATUS;
	localparam logic [3:0] DT = tw_pkg::REG_DATA;
	localparam logic [3:0] PT = tw_pkg::REG_PORT;
	logic       clk_sys;
	logic       rst;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic       irq_start;
	logic       irq_ovf;
	logic       wake;
	logic       cmd_valid;
	logic [1:0] cmd;
	logic [7:0] cmd_data;
	logic       cmd_ready;
	logic [7:0] rsp_data;
	logic       rsp_ack;
	logic       rsp_valid;
	logic [7:0] v;
	int         n_errors;
	int         comparisons;
	int         n_rsp;
	int         exp_rsp;
	int         cycles;
	tw_bus_if   bus ();

	tw_serial_unit i_tw_serial_unit (.clk_sys(clk_sys), .rst(rst),
		.ce(1'b1), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .irq_start(irq_start), .irq_ovf(irq_ovf),
		.wake(wake), .bus(bus));
	tw_bus_master i_tw_bus_master (.clk_sys(clk_sys), .rst(rst),
		.ce(1'b1), .cmd_valid(cmd_valid), .cmd(cmd),
		.cmd_data(cmd_data), .cmd_last(1'b0), .cmd_ready(cmd_ready),
		.rsp_data(rsp_data), .rsp_ack(rsp_ack), .rsp_valid(rsp_valid),
		.bus(bus));
	tw_line_asserts i_tw_line_asserts (.clk_sys(clk_sys), .rst(rst),
		.scl(bus.scl), .sda(bus.sda), .scl_oe_n_dev(bus.scl_oe_n_dev),
		.sda_oe_n_dev(bus.sda_oe_n_dev),
		.scl_oe_n_mst(bus.scl_oe_n_mst));

	// Clock
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Cycle ceiling and count of master responses
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (rsp_valid === 1'b1) n_rsp <= n_rsp + 1;
		if (cycles == 60000) begin
			n_errors++;
			results();
		end
	end

	task automatic results;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : results

	task automatic chk(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s exp %h seen %h", what, exp, seen);
		end
	endtask : chk

	// Register port: one-cycle strobes
	task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		#1;
	endtask : wr_reg
	task automatic rd_reg(input logic [3:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	// Master command handshake and wait for its response
	task automatic mcmd(input logic [1:0] c, input logic [7:0] d);
		@(posedge clk_sys);
		cmd_valid <= 1'b1;
		cmd       <= c;
		cmd_data  <= d;
		exp_rsp++;
		do @(negedge clk_sys); while (cmd_ready !== 1'b1);
		@(posedge clk_sys);
		cmd_valid <= 1'b0;
	endtask : mcmd
	task automatic wait_rsp;
		int k;
		for (k = 0; k < 5000 && n_rsp < exp_rsp; k++) @(posedge clk_sys);
		chk("responses", 8'(n_rsp), 8'(exp_rsp));
	endtask : wait_rsp

	// Slave software: wait for a byte, then acknowledge or not
	task automatic rx_head(input logic [7:0] b);
		int k;
		for (k = 0; k < 2000; k++) begin
			rd_reg(ST);
			if (v[tw_pkg::STAT_OVF] === 1'b1) break;
		end
		chk("byte status", v, 8'h40);
		rd_reg(DT);
		chk("byte", v, b);
	endtask : rx_head
	task automatic rx_tail(input logic ack);
		wr_reg(PT, ack ? 8'h02 : 8'h00);
		chk("ack sda", {7'h00, bus.sda}, {7'h00, !ack});
		wr_reg(ST, {4'h4, tw_pkg::CNT_ACK});
		wait_rsp();
		chk("ack seen", {7'h00, rsp_ack}, {7'h00, ack});
		repeat (4) @(posedge clk_sys);
		rd_reg(ST);
		chk("ack status", v, 8'h40);
		chk("ovf irq", {7'h00, irq_ovf}, 8'h01);
		wr_reg(PT, 8'h00);
		wr_reg(ST, 8'h40);
	endtask : rx_tail

	// Main sequence
	initial begin
		rst = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		cmd_valid = 1'b0;
		cmd = 2'h0;
		cmd_data = 8'h00;
		n_errors = 0;
		comparisons = 0;
		n_rsp = 0;
		exp_rsp = 0;
		cycles = 0;
		repeat (3) @(posedge clk_sys);
		rst <= 1'b0;
		rd_reg(CT);
		chk("ctrl reset", v, tw_pkg::RESET_CTRL);
		rd_reg(PT);
		chk("port reset", v, tw_pkg::RESET_PORT);
		wr_reg(4'h9, 8'hFF);
		rd_reg(4'h9);
		chk("unmapped", v, 8'h00);
		wr_reg(CT, 8'hCA);
		mcmd(tw_pkg::CMD_START, 8'h00);
		wait_rsp();
		mcmd(tw_pkg::CMD_WRITE, 8'hA4);
		repeat (300) @(posedge clk_sys);
		chk("scl held", {7'h00, bus.scl}, 8'h00);
		rd_reg(ST);
		chk("start flag", v & 8'hE0, 8'hA0);
		chk("wake", {6'h00, wake, irq_start}, 8'h03);
		wr_reg(ST, 8'h00);
		rd_reg(ST);
		chk("write zero", v & 8'hE0, 8'hA0);
		wr_reg(ST, 8'h80);
		rx_head(8'hA4);
		wr_reg(DT, 8'h00);
		wr_reg(PT, 8'h03);
		chk("sda bit7", {7'h00, bus.sda}, 8'h00);
		wr_reg(DT, 8'hFF);
		chk("sda free", {7'h00, bus.sda}, 8'h01);
		wr_reg(PT, 8'h00);
		wr_reg(DT, 8'h00);
		chk("sda undriven", {7'h00, bus.sda}, 8'h01);
		rx_tail(1'b1);
		mcmd(tw_pkg::CMD_WRITE, 8'h5A);
		rx_head(8'h5A);
		rx_tail(1'b0);
		mcmd(tw_pkg::CMD_STOP, 8'h00);
		wait_rsp();
		rd_reg(tw_pkg::REG_TIMER);
		chk("chain", v, 8'h04);
		wr_reg(ST, 8'h4F);
		wr_reg(CT, 8'h00);
		wr_reg(CT, 8'h20);
		rd_reg(ST);
		chk("soft strobe", v, 8'h40);
		chk("masked", {7'h00, irq_ovf}, 8'h00);
		rd_reg(tw_pkg::REG_TIMER);
		chk("chain", v, 8'h05);
		wr_reg(ST, 8'h4F);
		wr_reg(CT, 8'h88);
		mcmd(tw_pkg::CMD_START, 8'h00);
		wait_rsp();
		rd_reg(ST);
		chk("edge irq", v, 8'hC0);
		chk("edge ovf", {7'h00, irq_ovf}, 8'h01);
		mcmd(tw_pkg::CMD_STOP, 8'h00);
		wait_rsp();
		rd_reg(ST);
		chk("both edges", v, 8'hC1);
		results();
	end
endmodule : two_wire_serial_unit_start_detect_bench
